// ==== include/rpd_pkg.sv ====
// Constants and state types shared by the reactive power datapath.
package rpd_pkg;
   // ----------------------------------------------------------------
   // Register word indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_WAVE_SRC = 10'h00d;
   localparam logic [9:0] IDX_NL_SEL = 10'h00e;
   localparam logic [9:0] IDX_ACC_MODE = 10'h00f;
   localparam logic [9:0] IDX_IRQ_EN_LOW = 10'h0d9;
   localparam logic [9:0] IDX_IRQ_EN_HIGH = 10'h0db;
   localparam logic [9:0] IDX_IRQ_ST_LOW = 10'h0dc;
   localparam logic [9:0] IDX_IRQ_ST_HIGH = 10'h0de;
   localparam logic [9:0] IDX_LINE_CYCLE_COUNT = 10'h0e0;
   localparam logic [9:0] IDX_REACTIVE_GAIN = 10'h0e1;
   localparam logic [9:0] IDX_REACTIVE_OFFSET = 10'h0e2;
   localparam logic [9:0] IDX_WAVE_SAMPLE = 10'h0e3;
   localparam logic [9:0] IDX_LINE_ENERGY = 10'h0e4;
   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int BIT_SIGN_CHANGE = 0;
   localparam int BIT_NO_LOAD = 1;
   localparam int BIT_CYCLE_END = 0;
   localparam int BIT_WAVE_READY = 1;
   localparam int BIT_WAVE_ENABLE = 2;
   localparam int BIT_SIGN_POLARITY = 0;
   localparam int BIT_INTEGRATOR = 7;
   localparam int POS_WAVE_RATE = 2;
   localparam logic [1:0] WAVE_SRC_REACTIVE = 2'h2;
   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_LINE_CYCLE_COUNT = 16'h0000;
   localparam logic [11:0] RST_GAIN = 12'h000;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   // ----------------------------------------------------------------
   // Filter shifts and no-load thresholds in parts per million.
   // ----------------------------------------------------------------
   localparam int PHASE_SHIFT_K = 6;
   localparam int LPF_SHIFT_K = 4;
   localparam int GAIN_FRAC_BITS = 12;
   localparam int OFFSET_FRAC_BITS = 8;
   localparam int FULL_SCALE = 2 ** 23;
   localparam int NL_PPM_1 = 150;
   localparam int NL_PPM_2 = 75;
   localparam int NL_PPM_3 = 37;
   localparam logic [23:0] NL_THR_1 = 24'(FULL_SCALE / 1000000 * 0 + (FULL_SCALE / 1000) * NL_PPM_1 / 1000);
   localparam logic [23:0] NL_THR_2 = 24'((FULL_SCALE / 1000) * NL_PPM_2 / 1000);
   localparam logic [23:0] NL_THR_3 = 24'((FULL_SCALE / 1000) * NL_PPM_3 / 1000);

   typedef enum logic [1:0] {RPD_LC_IDLE, RPD_LC_ARM, RPD_LC_RUN} rpd_lc_state_t;

   typedef struct packed {
      logic [7:0] wave_src;
      logic [7:0] nl_sel;
      logic [7:0] acc_mode;
      logic [7:0] en_low;
      logic [7:0] en_high;
      logic [1:0] st_low;
      logic [1:0] st_high;
      logic [15:0] line_cycle_count;
      logic [11:0] reactive_gain;
      logic [15:0] reactive_offset;
      logic signed [31:0] shift_acc;
      logic signed [31:0] lpf_acc;
      logic signed [23:0] power;
      logic power_valid;
      logic prev_psign;
      logic prev_vsign;
      logic [2:0] dec_cnt;
      logic signed [23:0] wave_data;
      logic wave_valid;
      rpd_lc_state_t lc_state;
      logic [15:0] half_cnt;
      logic signed [31:0] lc_acc;
      logic signed [31:0] lc_result;
      logic [9:0] bus_idx;
      logic bus_wr;
      logic [31:0] rdata;
   } rpd_state_t;
endpackage

// ==== design/rpd_top.sv ====
// Reactive power datapath with AHB-Lite register slave and interrupt.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module rpd_top (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Digitised channels
   input wire logic sample_valid_in,
   input wire logic signed [23:0] voltage_sample_in,
   input wire logic signed [23:0] current_sample_in,
   // Results
   output logic signed [23:0] waveform_sample_out,
   output logic waveform_valid_out,
   output logic irq_out
);
   import rpd_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic signed [23:0] sat24(input logic signed [39:0] x);
      logic signed [39:0] hi;
      logic signed [39:0] lo;
      hi = 40'sh00_007f_ffff;
      lo = -40'sh00_0080_0000;
      if (x > hi) begin
         sat24 = 24'sh7f_ffff;
      end else if (x < lo) begin
         sat24 = -24'sh80_0000;
      end else begin
         sat24 = x[23:0];
      end
   endfunction

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h00_0000, b};
   endfunction

   rpd_state_t s_reg;
   rpd_state_t s_next;

   logic addr_phase;
   logic signed [31:0] cur_ext;
   logic signed [23:0] shifted;
   logic signed [47:0] product;
   logic signed [31:0] prod_ext;
   logic signed [23:0] power_raw;
   logic signed [36:0] gain_prod;
   logic signed [23:0] gained;
   logic signed [32:0] fine;
   logic signed [23:0] power_new;
   logic [24:0] power_mag;
   logic [23:0] nl_thr;
   logic no_load;
   logic new_psign;
   logic vsign;
   logic zero_cross;
   logic [2:0] dec_mask;
   logic [15:0] half_inc;
   logic signed [31:0] lc_sum;

   assign addr_phase = hsel_in && htrans_in[1] && hready_in;

   // ----------------------------------------------------------------
   // Arithmetic chain on the registered filter state
   // ----------------------------------------------------------------
   always_comb begin
      cur_ext = 32'(current_sample_in);
      // A leaky integrator lags the line-frequency current by close to a quarter
      // period; negating it gives the lead. The magnitude droop is the price of
      // keeping this to one adder.
      if (s_reg.acc_mode[BIT_INTEGRATOR]) begin
         shifted = 24'(s_reg.shift_acc >>> PHASE_SHIFT_K);
      end else begin
         shifted = 24'(-(s_reg.shift_acc >>> PHASE_SHIFT_K));
      end
      product = voltage_sample_in * shifted;
      prod_ext = 32'(signed'(product[46:23]));
      power_raw = 24'(s_reg.lpf_acc >>> LPF_SHIFT_K);
      gain_prod = power_raw * (14'sd4096 + 14'(signed'(s_reg.reactive_gain)));
      gained = sat24(40'(gain_prod >>> GAIN_FRAC_BITS));
      fine = (33'(gained) <<< OFFSET_FRAC_BITS) + 33'(signed'(s_reg.reactive_offset));
      power_new = sat24(40'(fine >>> OFFSET_FRAC_BITS));
      power_mag = power_new[23] ? 25'(-26'(power_new)) : 25'(power_new);
      case (s_reg.nl_sel[1:0])
         2'b01: nl_thr = NL_THR_1;
         2'b10: nl_thr = NL_THR_2;
         2'b11: nl_thr = NL_THR_3;
         default: nl_thr = 24'h00_0000;
      endcase
      no_load = (s_reg.nl_sel[1:0] != 2'b00) && (power_mag < {1'b0, nl_thr});
      new_psign = power_new[23];
      vsign = voltage_sample_in[23];
      zero_cross = vsign != s_reg.prev_vsign;
      case (s_reg.wave_src[POS_WAVE_RATE +: 2])
         2'b00: dec_mask = 3'h0;
         2'b01: dec_mask = 3'h1;
         2'b10: dec_mask = 3'h3;
         default: dec_mask = 3'h7;
      endcase
      half_inc = s_reg.half_cnt + 16'h0001;
      lc_sum = no_load ? s_reg.lc_acc : s_reg.lc_acc + 32'(power_new);
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.wave_valid = 1'b0;
      s_next.power_valid = 1'b0;
      // Register writes land in the data phase.
      if (s_reg.bus_wr) begin
         s_next.bus_wr = 1'b0;
         case (s_reg.bus_idx)
            IDX_WAVE_SRC: s_next.wave_src = hwdata_in[7:0];
            IDX_NL_SEL: s_next.nl_sel = hwdata_in[7:0];
            IDX_ACC_MODE: s_next.acc_mode = hwdata_in[7:0];
            IDX_IRQ_EN_LOW: s_next.en_low = hwdata_in[7:0];
            IDX_IRQ_EN_HIGH: s_next.en_high = hwdata_in[7:0];
            IDX_LINE_CYCLE_COUNT: begin
               s_next.line_cycle_count = hwdata_in[15:0];
               s_next.lc_result = 32'sh0000_0000;
               s_next.lc_acc = 32'sh0000_0000;
               s_next.half_cnt = 16'h0000;
               s_next.lc_state = (hwdata_in[15:0] != 16'h0000) ? RPD_LC_ARM : RPD_LC_IDLE;
            end
            IDX_REACTIVE_GAIN: s_next.reactive_gain = hwdata_in[11:0];
            IDX_REACTIVE_OFFSET: s_next.reactive_offset = hwdata_in[15:0];
            default: ;
         endcase
      end
      // Reads are served from the address phase so the data is a flop.
      if (addr_phase) begin
         s_next.bus_idx = haddr_in[11:2];
         s_next.bus_wr = hwrite_in;
         s_next.rdata = 32'h0000_0000;
         if (!hwrite_in) begin
            case (haddr_in[11:2])
               IDX_WAVE_SRC: s_next.rdata = byte_word(s_reg.wave_src);
               IDX_NL_SEL: s_next.rdata = byte_word(s_reg.nl_sel);
               IDX_ACC_MODE: s_next.rdata = byte_word(s_reg.acc_mode);
               IDX_IRQ_EN_LOW: s_next.rdata = byte_word(s_reg.en_low);
               IDX_IRQ_EN_HIGH: s_next.rdata = byte_word(s_reg.en_high);
               IDX_IRQ_ST_LOW: begin
                  s_next.rdata = byte_word({6'h00, s_reg.st_low});
                  s_next.st_low = 2'b00;
               end
               IDX_IRQ_ST_HIGH: begin
                  s_next.rdata = byte_word({6'h00, s_reg.st_high});
                  s_next.st_high = 2'b00;
               end
               IDX_LINE_CYCLE_COUNT: s_next.rdata = {16'h0000, s_reg.line_cycle_count};
               IDX_REACTIVE_GAIN: s_next.rdata = {20'h0_0000, s_reg.reactive_gain};
               IDX_REACTIVE_OFFSET: s_next.rdata = {16'h0000, s_reg.reactive_offset};
               IDX_WAVE_SAMPLE: s_next.rdata = 32'(s_reg.wave_data);
               IDX_LINE_ENERGY: s_next.rdata = s_reg.lc_result;
               default: s_next.rdata = 32'h0000_0000;
            endcase
         end
      end
      // Filters advance once per channel sample; events are applied after the
      // read clear above so that an event in the clearing cycle survives.
      if (sample_valid_in) begin
         // Unit gain at DC: the sum settles near the input times two to the
         // shift, so a full-scale current stays inside the 32-bit accumulator.
         s_next.shift_acc = s_reg.shift_acc + cur_ext
            - (s_reg.shift_acc >>> PHASE_SHIFT_K);
         s_next.lpf_acc = s_reg.lpf_acc + prod_ext - (s_reg.lpf_acc >>> LPF_SHIFT_K);
         s_next.power = power_new;
         s_next.power_valid = 1'b1;
         s_next.prev_psign = new_psign;
         s_next.prev_vsign = vsign;
         if (!s_reg.acc_mode[BIT_SIGN_POLARITY] && !s_reg.prev_psign && new_psign) begin
            s_next.st_low[BIT_SIGN_CHANGE] = 1'b1;
         end
         if (s_reg.acc_mode[BIT_SIGN_POLARITY] && s_reg.prev_psign && !new_psign) begin
            s_next.st_low[BIT_SIGN_CHANGE] = 1'b1;
         end
         if (no_load) begin
            s_next.st_low[BIT_NO_LOAD] = 1'b1;
         end
         // Waveform delivery at the decimated rate.
         s_next.dec_cnt = s_reg.dec_cnt + 3'h1;
         if ((s_reg.wave_src[1:0] == WAVE_SRC_REACTIVE) && s_reg.en_high[BIT_WAVE_ENABLE]
               && ((s_reg.dec_cnt & dec_mask) == 3'h0)) begin
            s_next.wave_data = power_new;
            s_next.wave_valid = 1'b1;
            s_next.st_high[BIT_WAVE_READY] = 1'b1;
         end
         // Line-cycle accumulation; a pending count write takes precedence.
         if (!s_reg.bus_wr || (s_reg.bus_idx != IDX_LINE_CYCLE_COUNT)) begin
            case (s_reg.lc_state)
               RPD_LC_IDLE: ;
               RPD_LC_ARM: begin
                  if (zero_cross) begin
                     s_next.lc_state = RPD_LC_RUN;
                     s_next.lc_acc = 32'sh0000_0000;
                     s_next.half_cnt = 16'h0000;
                  end
               end
               RPD_LC_RUN: begin
                  s_next.lc_acc = lc_sum;
                  if (zero_cross) begin
                     s_next.half_cnt = half_inc;
                     if (half_inc == s_reg.line_cycle_count) begin
                        s_next.lc_result = lc_sum;
                        s_next.lc_acc = 32'sh0000_0000;
                        s_next.half_cnt = 16'h0000;
                        s_next.st_high[BIT_CYCLE_END] = 1'b1;
                     end
                  end
               end
               default: s_next.lc_state = RPD_LC_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         s_reg.wave_src <= RST_BYTE;
         s_reg.nl_sel <= RST_BYTE;
         s_reg.acc_mode <= RST_BYTE;
         s_reg.en_low <= RST_BYTE;
         s_reg.en_high <= RST_BYTE;
         s_reg.st_low <= 2'b00;
         s_reg.st_high <= 2'b00;
         s_reg.line_cycle_count <= RST_LINE_CYCLE_COUNT;
         s_reg.reactive_gain <= RST_GAIN;
         s_reg.reactive_offset <= RST_OFFSET;
         s_reg.shift_acc <= 32'sh0000_0000;
         s_reg.lpf_acc <= 32'sh0000_0000;
         s_reg.power <= 24'sh00_0000;
         s_reg.power_valid <= 1'b0;
         s_reg.prev_psign <= 1'b0;
         s_reg.prev_vsign <= 1'b0;
         s_reg.dec_cnt <= 3'h0;
         s_reg.wave_data <= 24'sh00_0000;
         s_reg.wave_valid <= 1'b0;
         s_reg.lc_state <= RPD_LC_IDLE;
         s_reg.half_cnt <= 16'h0000;
         s_reg.lc_acc <= 32'sh0000_0000;
         s_reg.lc_result <= 32'sh0000_0000;
         s_reg.bus_idx <= 10'h000;
         s_reg.bus_wr <= 1'b0;
         s_reg.rdata <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The slave never stalls, so every transfer completes in one data phase.
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = s_reg.rdata;
   assign waveform_sample_out = s_reg.wave_data;
   assign waveform_valid_out = s_reg.wave_valid;
   assign irq_out = |(s_reg.st_low & s_reg.en_low[1:0])
      | |(s_reg.st_high & s_reg.en_high[1:0]);

endmodule

`default_nettype wire

// ==== test/rpd_props.sv ====
// Port-level assertions for the reactive power datapath, bound to its top.
`timescale 1ns/1ns
`default_nettype none
module rpd_props (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   // Register bus
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   // Datapath
   input wire logic sample_valid_in,
   input wire logic signed [23:0] waveform_sample_out,
   input wire logic waveform_valid_out,
   input wire logic irq_out
);
   import rpd_pkg::*;
   logic take;
   logic rd_take;
   logic wr_dp_reg;
   logic [9:0] idx_reg;
   logic wave_en_reg;
   logic [1:0] src_reg;
   assign take = hsel_in & htrans_in[1] & hready_in;
   assign rd_take = take & ~hwrite_in;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   // -------------------------------------------------------------
   // Shadow of enable and source, so delivery can be judged.
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         wr_dp_reg <= 1'b0;
         idx_reg <= 10'h000;
         wave_en_reg <= 1'b0;
         src_reg <= 2'h0;
      end else begin
         wr_dp_reg <= take & hwrite_in;
         if (take) begin
            idx_reg <= haddr_in[11:2];
         end
         if (wr_dp_reg && hready_in && idx_reg == IDX_IRQ_EN_HIGH) begin
            wave_en_reg <= hwdata_in[BIT_WAVE_ENABLE];
         end
         if (wr_dp_reg && hready_in && idx_reg == IDX_WAVE_SRC) begin
            src_reg <= hwdata_in[1:0];
         end
      end
   end
   // -------------------------------------------------------------
   // Assertions.
   // -------------------------------------------------------------
   a_ready_always: assert property (hreadyout_out == 1'b1)
      else $error("hreadyout dropped");
   a_resp_okay: assert property (hresp_out == 1'b0)
      else $error("error response seen");
   a_valid_cause: assert property (waveform_valid_out |-> $past(sample_valid_in))
      else $error("waveform valid without a sample");
   // The enable decision is made on the sample edge, so the old shadow counts.
   a_valid_enable: assert property (waveform_valid_out |->
      $past(wave_en_reg) && $past(src_reg) == WAVE_SRC_REACTIVE)
      else $error("waveform delivered while not selected");
   a_sample_hold: assert property (!waveform_valid_out |-> $stable(waveform_sample_out))
      else $error("waveform sample moved without valid");
   a_irq_rise: assert property ($rose(irq_out) |-> $past(sample_valid_in) || $past(wr_dp_reg))
      else $error("interrupt rose without an event");
   a_irq_fall: assert property ($fell(irq_out) |-> $past(rd_take) || $past(wr_dp_reg))
      else $error("interrupt fell without clear or mask");
   a_rdata_hold: assert property (!$past(take) |-> $stable(hrdata_out))
      else $error("read data moved outside an address phase");
   c_wave: cover property (waveform_valid_out);
   c_irq_up: cover property ($rose(irq_out));
   c_irq_down: cover property ($fell(irq_out));
endmodule
bind rpd_top rpd_props u_props (
   .clk_sys_in(clk_sys_in),
   .rstn_in(rstn_in),
   .hsel_in(hsel_in),
   .haddr_in(haddr_in),
   .htrans_in(htrans_in),
   .hwrite_in(hwrite_in),
   .hwdata_in(hwdata_in),
   .hready_in(hready_in),
   .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out),
   .sample_valid_in(sample_valid_in),
   .waveform_sample_out(waveform_sample_out),
   .waveform_valid_out(waveform_valid_out),
   .irq_out(irq_out)
);
`default_nettype wire

// ==== test/rpd_chan_src.sv ====
// Channel sample source standing in for the digitised voltage and current.
`timescale 1ns/1ns
`default_nettype none
module rpd_chan_src (
   // Clock and control
   input wire logic clk_sys_in,
   input wire logic go_in,
   input wire logic alt_in,
   input wire logic signed [23:0] v_lvl_in,
   input wire logic signed [23:0] i_lvl_in,
   // Channel samples
   output logic valid_out,
   output logic signed [23:0] v_out,
   output logic signed [23:0] i_out
);
   logic [1:0] cnt_reg = 2'h0;
   logic flip_reg = 1'b0;
   logic vld_reg = 1'b0;
   logic signed [23:0] v_reg = 24'h00_0000;
   logic signed [23:0] i_reg = 24'h00_0000;
   assign valid_out = vld_reg;
   assign v_out = v_reg;
   assign i_out = i_reg;
   // One sample every fourth cycle; between strobes the data lines toggle
   // every cycle so nothing can lean on a stale sample.
   always_ff @(posedge clk_sys_in) begin
      cnt_reg <= cnt_reg + 2'h1;
      vld_reg <= go_in && cnt_reg == 2'h3;
      if (go_in && cnt_reg == 2'h3) begin
         flip_reg <= alt_in ? ~flip_reg : 1'b0;
         v_reg <= (alt_in && flip_reg) ? -v_lvl_in : v_lvl_in;
         i_reg <= i_lvl_in;
      end else begin
         v_reg <= ~v_reg;
         i_reg <= ~i_reg;
      end
   end
endmodule
`default_nettype wire

// ==== test/reactive_power_datapath_test.sv ====
// Self-checking bench for the reactive power datapath.
`timescale 1ns/1ns
`default_nettype none
module reactive_power_datapath_test;
   import rpd_pkg::*;
   localparam logic signed [23:0] LVL_POS = 24'h10_0000;
   localparam logic signed [23:0] LVL_NEG = 24'hF0_0000;
   logic clk_sys_in, rstn_in, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, fl, f0;
   logic sv, wave_v, irq, go, alt;
   logic signed [23:0] vs, cs, wave, v_lvl, i_lvl;
   int err_total, num_checks, cnt;
   logic [9:0] ridx [9] = '{IDX_WAVE_SRC, IDX_NL_SEL, IDX_ACC_MODE, IDX_IRQ_EN_LOW,
      IDX_IRQ_EN_HIGH, IDX_LINE_CYCLE_COUNT, IDX_REACTIVE_GAIN, IDX_REACTIVE_OFFSET, 10'h3FF};
   logic [31:0] rmax [9] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF,
      32'h0000_00FF, 32'h0000_FFFF, 32'h0000_0FFF, 32'h0000_FFFF, 32'h0000_0000};
   rpd_top u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .sample_valid_in(sv), .voltage_sample_in(vs),
      .current_sample_in(cs), .waveform_sample_out(wave), .waveform_valid_out(wave_v),
      .irq_out(irq));
   rpd_chan_src u_src (.clk_sys_in(clk_sys_in), .go_in(go), .alt_in(alt), .v_lvl_in(v_lvl),
      .i_lvl_in(i_lvl), .valid_out(sv), .v_out(vs), .i_out(cs));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task automatic bus_op(input logic wr, input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk_sys_in);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys_in); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic samples(input int n);
      repeat (n) @(posedge clk_sys_in iff sv === 1'b1);
      repeat (2) @(posedge clk_sys_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge clk_sys_in);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
   initial begin
      {rstn_in, hsel, hwrite, go, alt, htrans} = '0;
      {haddr, hwdata, v_lvl, i_lvl} = '0;
      repeat (8) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      foreach (ridx[k]) begin
         bus_op(1'b0, ridx[k], 32'h0);
         chk(rd, 32'h0000_0000, "reset value");
         bus_op(1'b1, ridx[k], 32'hFFFF_FFFF);
         bus_op(1'b0, ridx[k], 32'h0);
         chk(rd, rmax[k], "register width");
         bus_op(1'b1, ridx[k], 32'h0);
      end
      $display("test registers done");
      go <= 1'b1;
      for (int r = 0; r < 6; r++) begin
         bus_op(1'b1, IDX_IRQ_EN_HIGH, (r == 4) ? 32'h0 : 32'h4);
         bus_op(1'b1, IDX_WAVE_SRC, {28'h0, r[1:0], (r == 5) ? 2'h1 : WAVE_SRC_REACTIVE});
         samples(8);
         cnt = 0;
         repeat (64) begin
            @(posedge clk_sys_in);
            if (wave_v === 1'b1) cnt++;
         end
         chk(cnt, (r > 3) ? 0 : 16 >> r, "waveform rate");
      end
      bus_op(1'b1, IDX_WAVE_SRC, {30'h0, WAVE_SRC_REACTIVE});
      bus_op(1'b1, IDX_REACTIVE_OFFSET, 32'h0000_0100);
      samples(4);
      chk({8'h00, wave}, 32'h0000_0001, "positive offset");
      bus_op(1'b1, IDX_REACTIVE_OFFSET, 32'h0000_FF00);
      samples(4);
      chk({8'h00, wave}, 32'h00FF_FFFF, "negative offset");
      bus_op(1'b1, IDX_REACTIVE_OFFSET, 32'h0);
      $display("test waveform done");
      for (int m = 0; m < 5; m++) begin
         go <= 1'b0;
         bus_op(1'b1, IDX_IRQ_EN_LOW, (m == 4) ? 32'h0 : 32'h2);
         bus_op(1'b1, IDX_NL_SEL, (m == 4) ? 32'h1 : m);
         bus_op(1'b0, IDX_IRQ_ST_LOW, 32'h0);
         chk({31'h0, irq}, 32'h0, "interrupt after clear");
         go <= 1'b1;
         samples(2);
         go <= 1'b0;
         chk({31'h0, irq}, {31'h0, m % 4 != 0}, "no-load interrupt");
         bus_op(1'b0, IDX_IRQ_ST_LOW, 32'h0);
         chk({30'h0, rd[1:0]}, (m == 0) ? 32'h0 : 32'h2, "no-load flag");
      end
      bus_op(1'b1, IDX_NL_SEL, 32'h0);
      bus_op(1'b1, IDX_IRQ_EN_LOW, 32'h1);
      $display("test no-load done");
      go <= 1'b1;
      v_lvl <= LVL_POS;
      for (int g = 0; g < 2; g++) begin
         for (int p = 0; p < 2; p++) begin
            bus_op(1'b1, IDX_ACC_MODE, {24'h0, g[0], 6'h0, p[0]});
            i_lvl <= LVL_POS;
            samples(300);
            bus_op(1'b0, IDX_IRQ_ST_LOW, 32'h0);
            i_lvl <= LVL_NEG;
            samples(300);
            bus_op(1'b0, IDX_IRQ_ST_LOW, 32'h0);
            fl[0] = rd[0];
            i_lvl <= LVL_POS;
            samples(300);
            bus_op(1'b0, IDX_IRQ_ST_LOW, 32'h0);
            fl[1] = rd[0];
            if (p == 0) begin
               f0 = fl;
               chk({31'h0, ^fl}, 32'h1, "one direction flagged");
            end else begin
               chk({30'h0, fl}, {30'h0, ~f0}, "polarity swaps direction");
            end
         end
      end
      $display("test sign done");
      go <= 1'b0;
      alt <= 1'b1;
      bus_op(1'b1, IDX_ACC_MODE, 32'h0);
      bus_op(1'b1, IDX_IRQ_EN_LOW, 32'h0);
      bus_op(1'b1, IDX_IRQ_EN_HIGH, 32'h1);
      bus_op(1'b1, IDX_LINE_CYCLE_COUNT, 32'h2);
      bus_op(1'b0, IDX_LINE_ENERGY, 32'h0);
      chk(rd, 32'h0, "result cleared by count write");
      bus_op(1'b0, IDX_IRQ_ST_HIGH, 32'h0);
      // The first crossing only starts a period; two more crossings close it.
      for (int n = 0; n < 5; n++) begin
         go <= 1'b1;
         samples((n == 0) ? 2 : 1);
         go <= 1'b0;
         chk({31'h0, irq}, {31'h0, n == 2 || n == 4}, "cycle end interrupt");
         bus_op(1'b0, IDX_IRQ_ST_HIGH, 32'h0);
         chk({31'h0, rd[BIT_CYCLE_END]}, {31'h0, n == 2 || n == 4}, "cycle end flag");
      end
      bus_op(1'b1, IDX_LINE_CYCLE_COUNT, 32'h2);
      bus_op(1'b0, IDX_LINE_ENERGY, 32'h0);
      chk(rd, 32'h0, "result cleared after a period");
      $display("test line cycle done");
      stop_test();
   end
endmodule
`default_nettype wire
